// ===== design/scf_pkg.sv
// Purpose: Shared constants and types for the sinc3 decimation filter.
// Assumes: One 200 MHz system clock; modulator bit rate is clock / 128.
// Notes:   Accumulator width covers 3*12 bits of growth plus sign.
package scf_pkg;
    localparam int unsigned SCF_MOD_DIV    = 128;   // Clocks per modulator bit.
    localparam int unsigned SCF_DIV_W      = 7;     // Divider counter width.
    localparam int unsigned SCF_N_W        = 12;    // Decimation word width.
    localparam int unsigned SCF_ACC_W      = 38;    // 3*12 growth, sign, spare.
    localparam int unsigned SCF_OUT_W      = 38;    // Output word width.
    localparam int unsigned SCF_STAGES     = 3;     // Filter order.
    localparam int unsigned SCF_SETTLE     = 3;     // Periods after a restart.
    localparam int unsigned SCF_STEP_MAX   = 4;     // Periods after a step.
    localparam logic [1:0]  SCF_SETTLE_CNT = 2'h3;  // Settle count value.
    localparam logic [SCF_DIV_W-1:0] SCF_DIV_LAST = 7'h7f; // Divider wrap.
    localparam logic [SCF_N_W-1:0]   SCF_N_MIN    = 12'h001; // Smallest N.

    // One filtered output sample with its strobe.
    typedef struct packed {
        logic                 valid;  // One-cycle strobe.
        logic [SCF_OUT_W-1:0] data;   // Signed filter output.
    } scf_out_t;

    // Settling tracker states.
    typedef enum logic [1:0] {
        SCF_ST_RUN,
        SCF_ST_SETTLE
    } scf_state_t;
endpackage : scf_pkg

// ===== design/scf_integrator.sv
// Purpose: Three cascaded integrators running at the modulator rate.
// Assumes: Input is +1/-1 coded as one bit; enable marks a new bit.
// Notes:   Wraparound arithmetic is intended; the combs undo it exactly.
`timescale 1ns/1ps
module scf_integrator
    import scf_pkg::*;
(
    input  wire logic                     clk_sys_in,  // System clock.
    input  wire logic                     rst_in,      // Async reset, high.
    input  wire logic                     clear_in,    // Restart filter.
    input  wire logic                     en_in,       // Modulator tick.
    input  wire logic                     bit_in,      // Modulator bit.
    output logic [scf_pkg::SCF_ACC_W-1:0] acc_out      // Third integrator.
);
    import scf_pkg::*;

    logic [SCF_ACC_W-1:0] acc1;  // First integrator.
    logic [SCF_ACC_W-1:0] acc2;  // Second integrator.
    logic [SCF_ACC_W-1:0] acc3;  // Third integrator.
    logic [SCF_ACC_W-1:0] samp;  // Bit mapped to +1 or -1.
    logic [SCF_ACC_W-1:0] next_acc1;  // First integrator with this bit.
    logic [SCF_ACC_W-1:0] next_acc2;  // Second integrator with this bit.
    logic [SCF_ACC_W-1:0] next_acc3;  // Third integrator with this bit.

    // A one maps to +1 and a zero to -1, so mid-scale gives zero.
    assign samp = bit_in ? {{(SCF_ACC_W-1){1'b0}}, 1'b1}
                         : {SCF_ACC_W{1'b1}};

    // The chain adds through in one step, so no stage lags the bit; a
    // pipelined chain would leave the first word after a restart short.
    assign next_acc1 = acc1 + samp;       // R1
    assign next_acc2 = acc2 + next_acc1;  // R1
    assign next_acc3 = acc3 + next_acc2;  // R1

    // Integrators advance only on the modulator tick.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            acc1 <= '0;
            acc2 <= '0;
            acc3 <= '0;
        end else if (clear_in) begin
            acc1 <= '0;
            acc2 <= '0;
            acc3 <= '0;
        end else if (en_in) begin
            acc1 <= next_acc1;  // R1
            acc2 <= next_acc2;  // R1
            acc3 <= next_acc3;  // R1
        end
    end

    // The sum includes the current bit; it is only meaningful on a tick.
    assign acc_out = next_acc3;
endmodule // scf_integrator

// ===== design/scf_sinc3.sv
// What this block does
// R1 - Third-order sinc filter as cascaded integrator-comb.
// R2 - Modulator bit every 128 clocks, decimated output.
// R3 - Output rate is clock over 128 times N.
// R4 - N changes notch spacing, never filter shape.
// R5 - Notches at every multiple of output rate.
// R6 - Cutoff is 0.262 of first notch.
// R7 - Linear phase, delay scales with N.
// R8 - Unsynchronised step settles within four periods.
// R9 - Sync or restart bit: valid after three periods.
// R10 - Channel change restarts; hold output three periods.
// R11 - Wide datapath gives 5% overrange headroom.
// R12 - One-cycle strobe marks each new output word.
//
// Purpose: Sinc3 decimation of a one-bit sigma-delta stream.
// Assumes: Modulator bit is a pin, resynchronised here.
// Notes:   Output is signed, full scale is +/- N cubed.
`timescale 1ns/1ps
module scf_sinc3
    import scf_pkg::*;
(
    input  wire logic                     clk_sys_in,       // System clock.
    input  wire logic                     rst_in,           // Async reset.
    input  wire logic                     mod_bit_in,       // Modulator pin.
    input  wire logic [scf_pkg::SCF_N_W-1:0] decim_word_in, // N word.
    input  wire logic                     sync_pin_in,      // Sync pin, async.
    input  wire logic                     filter_restart_bit_in, // Restart.
    input  wire logic                     chan_change_in,   // Channel switch.
    output scf_pkg::scf_out_t             result_out,       // Word + strobe.
    output logic                          settled_out,      // Output trusted.
    output logic                          mod_tick_out      // Modulator tick.
);
    import scf_pkg::*;

    // Pin synchronisers: three stages, change counts when 2 and 3 agree.
    logic [2:0] mod_sync;    // Modulator bit chain.
    logic [2:0] sync_sync;   // Sync pin chain.
    logic       mod_bit;     // Filtered modulator bit.
    logic       sync_lvl;    // Filtered sync level.
    logic       sync_lvl_d;  // Previous filtered sync level.

    // Pins are sampled into the system clock; glitches need two agreements.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            mod_sync  <= 3'h0;
            sync_sync <= 3'h0;
        end else begin
            mod_sync  <= {mod_sync[1:0], mod_bit_in};
            sync_sync <= {sync_sync[1:0], sync_pin_in};
        end
    end

    // Accepted levels move only when stages two and three agree.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            mod_bit    <= 1'b0;
            sync_lvl   <= 1'b0;
            sync_lvl_d <= 1'b0;
        end else begin
            if (mod_sync[1] == mod_sync[2]) begin
                mod_bit <= mod_sync[2];
            end
            if (sync_sync[1] == sync_sync[2]) begin
                sync_lvl <= sync_sync[2];
            end
            sync_lvl_d <= sync_lvl;
        end
    end

    // A restart from any of the three sources; only the sync pin is taken as one pulse.
    logic restart;  // Filter restart request this cycle.
    assign restart = (sync_lvl & ~sync_lvl_d) | filter_restart_bit_in
                   | chan_change_in;  // R9 R10

    // Modulator rate divider: one tick every 128 clocks.
    logic [SCF_DIV_W-1:0] div_cnt;  // Clock divider.
    logic                 tick;     // Modulator-rate enable.
    assign tick = (div_cnt == SCF_DIV_LAST);

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            div_cnt <= '0;
        end else if (restart) begin
            div_cnt <= '0;  // R9
        end else begin
            div_cnt <= div_cnt + 1'b1;  // R2
        end
    end

    // Integrator stages live in their own module.
    logic [SCF_ACC_W-1:0] integ;  // Third integrator output.
    scf_integrator u_integ (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .clear_in   (restart),
        .en_in      (tick),
        .bit_in     (mod_bit),
        .acc_out    (integ)
    );

    // Decimation counter: one output per N modulator samples.
    // N is latched at each output so a mid-period write cannot distort it.
    logic [SCF_N_W-1:0] n_cur;    // N in use this period.
    logic [SCF_N_W-1:0] dec_cnt;  // Samples taken this period.
    logic               dec_hit;  // Last sample of the period.
    logic [SCF_N_W-1:0] n_next;   // Word to use from next period.

    // N of zero is treated as one so the divider always terminates.
    function automatic logic [SCF_N_W-1:0] safe_n(input logic [SCF_N_W-1:0] w);
        return (w < SCF_N_MIN) ? SCF_N_MIN : w;
    endfunction

    assign n_next  = safe_n(decim_word_in);
    assign dec_hit = tick && (dec_cnt == n_cur - SCF_N_MIN);  // R3

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            dec_cnt <= '0;
            n_cur   <= SCF_N_MIN;
        end else if (restart) begin
            dec_cnt <= '0;
            n_cur   <= n_next;  // R4
        end else if (dec_hit) begin
            dec_cnt <= '0;
            n_cur   <= n_next;  // R4
        end else if (tick) begin
            dec_cnt <= dec_cnt + 1'b1;
        end
    end

    // Comb stages at the output rate; each differences over one period,
    // which places notches at every multiple of the output rate.
    logic [SCF_ACC_W-1:0] d1;   // Delay of comb input.
    logic [SCF_ACC_W-1:0] d2;   // Delay of first comb.
    logic [SCF_ACC_W-1:0] d3;   // Delay of second comb.
    logic [SCF_ACC_W-1:0] c1;   // First comb.
    logic [SCF_ACC_W-1:0] c2;   // Second comb.
    logic [SCF_ACC_W-1:0] c3;   // Third comb, filter result.
    assign c1 = integ - d1;     // R1 R5
    assign c2 = c1 - d2;        // R1 R5
    assign c3 = c2 - d3;        // R1 R5

    // Symmetric taps keep phase linear; width covers N cubed plus sign,
    // so a 5% overrange never wraps (R6 and R7 follow from the structure).
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            d1 <= '0;
            d2 <= '0;
            d3 <= '0;
        end else if (restart) begin
            d1 <= '0;
            d2 <= '0;
            d3 <= '0;
        end else if (dec_hit) begin
            d1 <= integ;  // R6 R7 R11
            d2 <= c1;
            d3 <= c2;
        end
    end

    // Settling: after a restart, three periods pass before output is real.
    // An unsynchronised step is flushed by the pipeline within four periods
    // on its own; nothing here can detect it, so only a status is given.
    scf_state_t st;          // Settling state.
    logic [1:0] settle_cnt;  // Periods left until the first output word.

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st         <= SCF_ST_SETTLE;
            settle_cnt <= SCF_SETTLE_CNT;
        end else if (restart) begin
            st         <= SCF_ST_SETTLE;  // R9 R10
            settle_cnt <= SCF_SETTLE_CNT;
        end else if (dec_hit) begin
            case (st)
                SCF_ST_SETTLE: begin
                    settle_cnt <= settle_cnt - 1'b1;
                    if (settle_cnt == 2'h1) begin
                        st <= SCF_ST_RUN;  // R9
                    end
                end
                SCF_ST_RUN: begin
                    st <= SCF_ST_RUN;  // R8
                end
                default: begin
                    st <= SCF_ST_SETTLE;
                end
            endcase
        end
    end

    // Output register: words only pass once the filter is settled.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            result_out  <= '0;
            settled_out <= 1'b0;
        end else begin
            result_out.valid <= 1'b0;
            if (restart) begin
                settled_out <= 1'b0;
            end else if (dec_hit) begin
                if (st == SCF_ST_RUN || settle_cnt == 2'h1) begin
                    result_out.valid <= 1'b1;  // R12
                    result_out.data  <= c3;    // R10
                    settled_out      <= 1'b1;
                end
            end
        end
    end

    // Tick is exported registered for downstream timing.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            mod_tick_out <= 1'b0;
        end else begin
            mod_tick_out <= tick;
        end
    end

    // Strobe is never two cycles long.
    property p_strobe_one;
        @(posedge clk_sys_in) disable iff (rst_in)
        result_out.valid |=> !result_out.valid;
    endproperty
    a_strobe_one: assert property (p_strobe_one)  // R12
        else $error("valid strobe longer than one cycle");

    // No tick within 8 clocks after a tick; the divider gives 128.
    property p_tick_gap;
        @(posedge clk_sys_in) disable iff (rst_in)
        tick |=> (!tick) [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap)  // R2
        else $error("modulator ticks too close");

    // No output word in the 8 cycles after a restart.
    property p_no_early;
        @(posedge clk_sys_in) disable iff (rst_in)
        restart |=> !result_out.valid [*8];
    endproperty
    a_no_early: assert property (p_no_early)  // R9
        else $error("output after restart too early");

    // Channel change clears settled status next cycle.
    property p_restart_clear;
        @(posedge clk_sys_in) disable iff (rst_in)
        chan_change_in |=> !settled_out;
    endproperty
    a_restart_clear: assert property (p_restart_clear)  // R10
        else $error("settled not cleared on channel change");

    // Output words come only on a period end.
    property p_on_period;
        @(posedge clk_sys_in) disable iff (rst_in)
        result_out.valid |-> $past(dec_hit);
    endproperty
    a_on_period: assert property (p_on_period)  // R3
        else $error("output not on decimation boundary");

    // Decimation count never exceeds N minus one.
    property p_cnt_bound;
        @(posedge clk_sys_in) disable iff (rst_in)
        dec_cnt < n_cur;
    endproperty
    a_cnt_bound: assert property (p_cnt_bound)  // R4
        else $error("decimation counter overran N");

    // Comb delay d1 changes only at a period end or a restart.
    property p_comb_hold;
        @(posedge clk_sys_in) disable iff (rst_in)
        (!dec_hit && !restart) |=> $stable(d1);
    endproperty
    a_comb_hold: assert property (p_comb_hold)  // R1
        else $error("comb delay changed off period");

    // Settled state entered only with a strobe.
    property p_run_strobe;
        @(posedge clk_sys_in) disable iff (rst_in)
        $rose(settled_out) |-> result_out.valid;
    endproperty
    a_run_strobe: assert property (p_run_strobe)  // R8
        else $error("settled without output word");
endmodule // scf_sinc3

// ===== verification/scf_mod_model.sv
// Purpose: Far-side model, the modulator bit source and output register.
// Assumes: The bench picks the level; one bit is taken per tick.
// Notes:   The register loads only on the strobe, as the real one does.
`timescale 1ns/1ps
module scf_mod_model
    import scf_pkg::*;
(
    input  wire logic                     clk_sys_in,  // System clock.
    input  wire logic                     rst_in,      // Async reset, high.
    input  wire logic                     level_in,    // Wanted bit level.
    input  wire scf_pkg::scf_out_t        result_in,   // Filter output.
    output logic                          mod_bit_out, // Modulator pin.
    output logic [scf_pkg::SCF_OUT_W-1:0] data_reg_out // Captured word.
);
    // The bit is launched just after an edge, so the synchroniser in
    // the filter sees a settled level long before the next tick.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            mod_bit_out <= 1'b0;         // Idle level out of reset.
        end else begin
            mod_bit_out <= level_in;
        end
    end

    // A missed strobe leaves stale data here, which the bench sees.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            data_reg_out <= '0;          // Empty register.
        end else if (result_in.valid) begin
            data_reg_out <= result_in.data;
        end
    end
endmodule // scf_mod_model

// ===== verification/sinc3_decimation_filter_test.sv
// Purpose: Self-checking bench for the sinc3 decimation filter.
// Assumes: The modulator level changes only at a restart or just after an output word.
// Notes:   Expected words are a direct sinc3 sum over a sample queue.
`timescale 1ns/1ps
module sinc3_decimation_filter_test;
    import scf_pkg::*;
    logic                 clk_sys_in;   // 200 MHz clock.
    logic                 rst_in;       // Reset, high.
    logic                 level;        // Modulator level.
    logic [SCF_N_W-1:0]   decim_word;   // Decimation word.
    logic                 sync_pin;     // Sync pin.
    logic                 restart_bit;  // Restart bit.
    logic                 chan_change;  // Channel switch.
    scf_out_t             result;       // Filter output.
    logic                 settled;      // Output trusted.
    logic                 mod_tick;     // Modulator tick.
    logic                 mod_bit;      // Modulator pin.
    logic [SCF_OUT_W-1:0] data_reg;     // Far-side register.
    int                   mismatches;   // Failed checks.
    int                   total_checks; // All checks.
    int                   cycles;       // Run length.
    int                   seed;         // Random seed.
    int                   q[$];         // Samples since restart.

    scf_sinc3 u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .mod_bit_in(mod_bit), .decim_word_in(decim_word),
        .sync_pin_in(sync_pin), .filter_restart_bit_in(restart_bit),
        .chan_change_in(chan_change), .result_out(result),
        .settled_out(settled), .mod_tick_out(mod_tick));
    scf_mod_model u_mod (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .level_in(level), .result_in(result), .mod_bit_out(mod_bit),
        .data_reg_out(data_reg));

    // Free-running clock, 5 ns period.
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end

    task automatic conclude();
        if (mismatches == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Cuts a hang short; the worst run is well under this count.
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic chk_val(input logic [SCF_OUT_W-1:0] g, e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_num(input logic [31:0] g, e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_bit(input logic g, e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Cube of an n-sample boxcar, as a triple sum; zeros before restart.
    function automatic logic [SCF_OUT_W-1:0] sinc3(int n);
        longint acc = 0;
        for (int i = 0; i < n; i++)
            for (int j = 0; j < n; j++)
                for (int k = 0; k < n; k++)
                    if (q.size() > i + j + k)
                        acc += q[q.size() - 1 - i - j - k];
        return acc[SCF_OUT_W-1:0];
    endfunction

    // Waits for the strobe, counting cycles and ticks; flags a settled
    // output seen before the first word once restart has had time.
    task automatic wait_word(input int start, output int lat,
                             output int ticks, output logic bad);
        lat = start;
        ticks = 0;
        bad = 1'b0;
        while (lat < 20000) begin
            @(posedge clk_sys_in);
            #1;
            lat++;
            if (mod_tick === 1'b1) ticks++;
            if (result.valid === 1'b1) break;
            if (lat > 8 && settled !== 1'b0) bad = 1'b1;
        end
    endtask

    initial begin
        int lat;
        int ticks;
        int n;
        int ne;
        int src;
        int lv;
        logic bad;
        logic [SCF_OUT_W-1:0] exp;
        {level, sync_pin, restart_bit, chan_change} = 4'h0;
        decim_word = 12'h001;
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        seed = 32'h8e35;
        rst_in = 1'b1;
        repeat (4) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        // Each pass restarts from a random point, mid-period included.
        for (int t = 0; t < 8; t++) begin
            n = (t < 3) ? t : 1 + ($unsigned($random(seed)) % 10);
            ne = (n == 0) ? 1 : n;
            src = t % 3;
            lv = $random(seed);
            repeat ($unsigned($random(seed)) % 200 + 2) @(posedge clk_sys_in);
            decim_word <= n[SCF_N_W-1:0];
            level <= lv[0];
            case (src)
                0: restart_bit <= 1'b1;
                1: chan_change <= 1'b1;
                default: sync_pin <= 1'b1;
            endcase
            @(posedge clk_sys_in);
            // The sync pin stays high until the first word, so that the
            // pin filter, which needs two agreeing stages, accepts it.
            {restart_bit, chan_change} <= 2'h0;
            q.delete();
            repeat (3 * ne) q.push_back(lv[0] ? 1 : -1);
            wait_word(0, lat, ticks, bad);
            chk_bit(lat >= 384 * ne - 1 &&
                    lat <= 384 * ne + (src == 2 ? 6 : 2), 1'b1);
            chk_bit(bad, 1'b0);
            chk_bit(settled, 1'b1);
            exp = sinc3(ne);
            chk_val(result.data, exp);
            for (int w = 0; w < 3; w++) begin
                @(posedge clk_sys_in);
                lv = $random(seed);
                level <= lv[0];
                sync_pin <= 1'b0;
                #1;
                chk_bit(result.valid, 1'b0);
                chk_val(data_reg, exp);
                repeat (ne) q.push_back(lv[0] ? 1 : -1);
                wait_word(1, lat, ticks, bad);
                chk_num(lat, 128 * ne);
                chk_num(ticks, ne);
                exp = sinc3(ne);
                chk_val(result.data, exp);
            end
        end
        conclude();
    end
endmodule // sinc3_decimation_filter_test
